// >>> hw/slice_ctl_pkg.sv
// Purpose: Shared constants and types for the slice-array controller.
// Assumes: 32-bit APB, four-bit slices, one common clock.
// Notes: Register offsets are byte addresses of aligned words.
package slice_ctl_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;   // Microword to issue.
    localparam logic [7:0] OFF_ISSUE = 8'h04;  // Write starts one issue.
    localparam logic [7:0] OFF_STATUS = 8'h08; // Flags and busy.
    localparam logic [7:0] OFF_RESULT = 8'h0C; // Captured end shift lines.

    // ------------------------------------------------------------
    // Control word field positions
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;  // Two-bit end shift mode.
    localparam int CTRL_DIR_BIT = 2;   // Shift direction bit (up when set).
    localparam int CTRL_SHIFT_BIT = 3; // Register-file word shifts.
    localparam int CTRL_AUX_BIT = 4;   // Auxiliary register also shifts.
    localparam int CTRL_CIN_BIT = 5;   // Carry into the least slice.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Status word field positions
    // ------------------------------------------------------------
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_CARRY_BIT = 1;
    localparam int STAT_OVF_BIT = 2;
    localparam int STAT_SIGN_BIT = 3;
    localparam int STAT_BUSY_BIT = 8;

    // End shift modes.
    typedef enum logic [1:0] {
        MODE_ZERO = 2'h0,
        MODE_ONE = 2'h1,
        MODE_ROTATE = 2'h2,
        MODE_ARITH = 2'h3
    } shift_mode_t;

    // Microword as held in the pipeline register.
    typedef struct packed {
        logic cin;
        logic aux_shift;
        logic shift_en;
        logic dir_up;
        shift_mode_t mode;
    } microword_t;

    // Processor status word gathered from the array.
    typedef struct packed {
        logic sign;
        logic ovf;
        logic carry;
        logic zero;
    } status_t;

endpackage : slice_ctl_pkg

// >>> hw/slice_ctl.sv
// Purpose: Controller driving a cascade of four-bit slices: pipeline register,
//          end-of-array shift multiplexers, carry-in and status capture.
// Assumes: Slices share this clock; array pins are asynchronous to it.
// Notes: Software reaches the controller over APB; the array has no bus port.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps

module slice_ctl
    import slice_ctl_pkg::*;
#(
    parameter int WIDTH = 16 // Array width in bits.
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [3:0] shift_direction_bit,
    output logic shift_enable,
    output logic aux_shift_enable,
    output logic slice_carry_in,
    input wire logic regfile_shift_lsb_port_i,
    output logic regfile_shift_lsb_port_o,
    output logic regfile_shift_lsb_port_oe,
    input wire logic regfile_shift_msb_port_i,
    output logic regfile_shift_msb_port_o,
    output logic regfile_shift_msb_port_oe,
    input wire logic aux_shift_lsb_port_i,
    output logic aux_shift_lsb_port_o,
    output logic aux_shift_lsb_port_oe,
    input wire logic aux_shift_msb_port_i,
    output logic aux_shift_msb_port_o,
    output logic aux_shift_msb_port_oe,
    input wire logic zero_line,
    input wire logic slice_carry_out,
    input wire logic signed_overflow_flag,
    input wire logic result_sign_bit
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Slices are four bits each, so the array must be a whole number of them.
    if (WIDTH < 4 || (WIDTH % 4) != 0) begin : g_width_chk
        $error("WIDTH must be a positive multiple of four");
    end

    // ------------------------------------------------------------
    // Software-visible state
    // ------------------------------------------------------------
    microword_t ctrl_q;    // Staged microword, written by software.
    microword_t ctrl_d;    // Next staged microword.
    microword_t pipe_q;    // Pipeline register feeding the array.
    microword_t pipe_d;    // Word entering the pipeline at the next edge.
    logic issue_q;         // One-cycle request: load pipeline now.
    logic exec_q;          // Array executes the pipelined word this cycle.
    status_t stat_q;       // Flags captured after execution.
    logic [3:0] ends_q;    // End shift line levels seen last execution.
    logic [31:0] prdata_d; // Read mux result.

    // ------------------------------------------------------------
    // Pin synchronisers (two stages, first read by second only)
    // ------------------------------------------------------------
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic [7:0] pin_raw;

    assign pin_raw = {regfile_shift_lsb_port_i, regfile_shift_msb_port_i,
                      aux_shift_lsb_port_i, aux_shift_msb_port_i,
                      zero_line, slice_carry_out, signed_overflow_flag,
                      result_sign_bit};

    // Sampled flags and end lines after synchronisation.
    wire rf_lsb_s = pin_s2_q[7];
    wire rf_msb_s = pin_s2_q[6];
    wire aux_lsb_s = pin_s2_q[5];
    wire aux_msb_s = pin_s2_q[4];
    wire zero_s = pin_s2_q[3];
    wire carry_s = pin_s2_q[2];
    wire ovf_s = pin_s2_q[1];
    wire sign_s = pin_s2_q[0];

    // Both stages take constants under reset; data moves on each edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Slave answers in the first access cycle; pready is held high.
    wire acc = psel && penable;
    wire wr_ctrl = acc && pwrite && (paddr[7:0] == OFF_CTRL);
    wire wr_issue = acc && pwrite && (paddr[7:0] == OFF_ISSUE);
    wire hit = (paddr[7:0] == OFF_CTRL) || (paddr[7:0] == OFF_ISSUE) ||
               (paddr[7:0] == OFF_STATUS) || (paddr[7:0] == OFF_RESULT);
    wire busy = issue_q || exec_q;

    assign ctrl_d = wr_ctrl ? microword_t'(pwdata[5:0]) : ctrl_q;

    // Idle cycles load the reset word, so the end lines fall back to zero mode.
    assign pipe_d = issue_q ? ctrl_q : microword_t'(CTRL_RESET[5:0]);

    // Read mux; unmapped offsets read zero and flag an error.
    always_comb begin
        prdata_d = 32'h0000_0000;
        if (paddr[7:0] == OFF_CTRL) begin
            prdata_d[5:0] = ctrl_q;
        end else if (paddr[7:0] == OFF_STATUS) begin
            prdata_d[3:0] = stat_q;
            prdata_d[STAT_BUSY_BIT] = busy;
        end else if (paddr[7:0] == OFF_RESULT) begin
            prdata_d[3:0] = ends_q;
        end
    end

    // Bus answer registers; read data is taken on the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b1;
            pslverr <= 1'b0;
        end else begin
            prdata <= prdata_d;
            pready <= 1'b1;
            pslverr <= psel && !penable && !hit;
        end
    end

    // ------------------------------------------------------------
    // Microword staging and pipeline
    // ------------------------------------------------------------
    // Software stages a word, then a write to the issue offset moves it into
    // the pipeline; the array executes it in the cycle after the load.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= microword_t'(CTRL_RESET[5:0]);
            issue_q <= 1'b0;
            pipe_q <= microword_t'(CTRL_RESET[5:0]);
            exec_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            issue_q <= wr_issue;
            pipe_q <= pipe_d;
            exec_q <= issue_q;
        end
    end

    // ------------------------------------------------------------
    // End-of-array shift multiplexers
    // ------------------------------------------------------------
    // The direction bit picks which end drives; the other end listens.
    // The vacated-bit source depends on the shared two-bit mode field.
    logic rf_in_d;
    logic aux_in_d;

    always_comb begin
        rf_in_d = 1'b0;
        aux_in_d = 1'b0;
        // Decoding the incoming word keeps the end levels in step with the
        // enables; decoding the held word would lag the shift by one cycle.
        unique case (pipe_d.mode)
            MODE_ZERO: begin
                rf_in_d = 1'b0;
                aux_in_d = 1'b0;
            end
            MODE_ONE: begin
                rf_in_d = 1'b1;
                aux_in_d = 1'b1;
            end
            MODE_ROTATE: begin
                // Up: top bit wraps to bottom; down: bottom wraps to top.
                rf_in_d = pipe_d.dir_up ? rf_msb_s : rf_lsb_s;
                aux_in_d = pipe_d.dir_up ? aux_msb_s : aux_lsb_s;
            end
            MODE_ARITH: begin
                // Up: zero into aux bottom, aux top into word bottom.
                // Down: sign into word top, word bottom into aux top.
                rf_in_d = pipe_d.dir_up ? aux_msb_s : sign_s;
                aux_in_d = pipe_d.dir_up ? 1'b0 : rf_lsb_s;
            end
        endcase
    end

    // Pin drivers; enables gate the three-state ends by direction.
    // Rotate and arithmetic read pins through the synchroniser, so their
    // inserted bit reflects the line two cycles old: a known limitation
    // of sampling asynchronous array pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regfile_shift_lsb_port_o <= 1'b0;
            regfile_shift_lsb_port_oe <= 1'b0;
            regfile_shift_msb_port_o <= 1'b0;
            regfile_shift_msb_port_oe <= 1'b0;
            aux_shift_lsb_port_o <= 1'b0;
            aux_shift_lsb_port_oe <= 1'b0;
            aux_shift_msb_port_o <= 1'b0;
            aux_shift_msb_port_oe <= 1'b0;
        end else begin
            regfile_shift_lsb_port_o <= rf_in_d;
            regfile_shift_msb_port_o <= rf_in_d;
            aux_shift_lsb_port_o <= aux_in_d;
            aux_shift_msb_port_o <= aux_in_d;
            // Up shift drives the bottom end, down shift drives the top.
            regfile_shift_lsb_port_oe <= issue_q && ctrl_q.shift_en && ctrl_q.dir_up;
            regfile_shift_msb_port_oe <= issue_q && ctrl_q.shift_en && !ctrl_q.dir_up;
            aux_shift_lsb_port_oe <= issue_q && ctrl_q.aux_shift && ctrl_q.dir_up;
            aux_shift_msb_port_oe <= issue_q && ctrl_q.aux_shift && !ctrl_q.dir_up;
        end
    end

    // Instruction outputs to the array, valid in the execute cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_direction_bit <= 4'h0;
            shift_enable <= 1'b0;
            aux_shift_enable <= 1'b0;
            slice_carry_in <= 1'b0;
        end else begin
            shift_direction_bit <= {3'h0, issue_q && ctrl_q.dir_up};
            shift_enable <= issue_q && ctrl_q.shift_en;
            aux_shift_enable <= issue_q && ctrl_q.aux_shift;
            slice_carry_in <= issue_q && ctrl_q.cin;
        end
    end

    // ------------------------------------------------------------
    // Status capture
    // ------------------------------------------------------------
    // Flags settle during execution; they are sampled two cycles after
    // through the synchroniser, i.e. when exec is two edges old.
    logic exec_d1_q;
    logic exec_d2_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_d1_q <= 1'b0;
            exec_d2_q <= 1'b0;
            stat_q <= '0;
            ends_q <= 4'h0;
        end else begin
            exec_d1_q <= exec_q;
            exec_d2_q <= exec_d1_q;
            if (exec_d2_q) begin
                stat_q.zero <= zero_s;
                stat_q.carry <= carry_s;
                stat_q.ovf <= ovf_s;
                stat_q.sign <= sign_s;
                ends_q <= {rf_lsb_s, rf_msb_s, aux_lsb_s, aux_msb_s};
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    pipe_exec_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_issue |=> issue_q ##1 exec_q) else $error("issue not executed");
    one_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(regfile_shift_lsb_port_oe && regfile_shift_msb_port_oe))
        else $error("both word ends driven");
    aux_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(aux_shift_lsb_port_oe && aux_shift_msb_port_oe))
        else $error("both aux ends driven");
    zero_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pipe_q.mode == MODE_ZERO) |-> !regfile_shift_lsb_port_o && !aux_shift_msb_port_o)
        else $error("zero mode inserted high");
    one_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pipe_q.mode == MODE_ONE) |-> regfile_shift_msb_port_o && aux_shift_lsb_port_o)
        else $error("one mode inserted low");
    rot_up_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pipe_q.mode == MODE_ROTATE && pipe_q.dir_up) |->
        regfile_shift_lsb_port_o == $past(rf_msb_s)) else $error("rotate up wrong");
    rot_aux_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pipe_q.mode == MODE_ROTATE && !pipe_q.dir_up) |->
        aux_shift_msb_port_o == $past(aux_lsb_s)) else $error("aux rotate wrong");
    arith_up_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pipe_q.mode == MODE_ARITH && pipe_q.dir_up) |->
        !aux_shift_lsb_port_o && regfile_shift_lsb_port_o == $past(aux_msb_s))
        else $error("arith up wrong");
    arith_dn_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pipe_q.mode == MODE_ARITH && !pipe_q.dir_up) |->
        regfile_shift_msb_port_o == $past(sign_s) && aux_shift_msb_port_o == $past(rf_lsb_s))
        else $error("arith down wrong");
    flag_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_d2_q |=> stat_q.carry == $past(carry_s) && stat_q.ovf == $past(ovf_s))
        else $error("flags not captured");

    issue_c: cover property (@(posedge pclk) disable iff (!presetn) wr_issue ##2 exec_q);
    arith_c: cover property (@(posedge pclk) disable iff (!presetn)
        exec_q && pipe_q.mode == MODE_ARITH);
    rot_c: cover property (@(posedge pclk) disable iff (!presetn)
        exec_q && pipe_q.mode == MODE_ROTATE && pipe_q.aux_shift);

endmodule : slice_ctl

// >>> bench/slice_array_model.sv
// Purpose: Behavioural cascade of four-bit slices facing the controller.
// Assumes: WIDTH is a multiple of four; the ALU adds op_a, op_b and carry in.
// Notes: An end pin the controller leaves idle shows the slice shift-out bit.
`timescale 1ns/1ps
module slice_array_model #(
    parameter int WIDTH = 16
) (
    input wire logic pclk,
    input wire logic [3:0] shift_direction_bit,
    input wire logic shift_enable,
    input wire logic aux_shift_enable,
    input wire logic slice_carry_in,
    input wire logic regfile_shift_lsb_port_o,
    input wire logic regfile_shift_lsb_port_oe,
    input wire logic regfile_shift_msb_port_o,
    input wire logic regfile_shift_msb_port_oe,
    input wire logic aux_shift_lsb_port_o,
    input wire logic aux_shift_lsb_port_oe,
    input wire logic aux_shift_msb_port_o,
    input wire logic aux_shift_msb_port_oe,
    output logic regfile_shift_lsb_port_i,
    output logic regfile_shift_msb_port_i,
    output logic aux_shift_lsb_port_i,
    output logic aux_shift_msb_port_i,
    output logic zero_line,
    output logic slice_carry_out,
    output logic signed_overflow_flag,
    output logic result_sign_bit,
    input wire logic [WIDTH-1:0] op_a,
    input wire logic [WIDTH-1:0] op_b,
    input wire logic q_load,
    input wire logic [WIDTH-1:0] q_init,
    output logic [WIDTH-1:0] q_q,
    output logic rf_in_q,
    output logic [7:0] shift_cnt
);
    logic [WIDTH-1:0] f; // ALU output of the whole array.
    logic [4:0] s5; // One slice sum with its carry out.
    logic c; // Carry rippling between slices.

    // Ripple carry slice by slice; any non-zero slice pulls the zero line low.
    always_comb begin
        c = slice_carry_in;
        zero_line = 1'b1;
        for (int n = 0; n < WIDTH / 4; n++) begin
            s5 = {1'b0, op_a[4*n+:4]} + {1'b0, op_b[4*n+:4]} + {4'h0, c};
            f[4*n+:4] = s5[3:0];
            c = s5[4];
            if (s5[3:0] != 4'h0) zero_line = 1'b0;
        end
        slice_carry_out = c;
        signed_overflow_flag = c ^ op_a[WIDTH-1] ^ op_b[WIDTH-1] ^ f[WIDTH-1];
        result_sign_bit = f[WIDTH-1];
    end

    // The controller wins a pin while it drives; the bit it sees otherwise
    // is kinder than a real slice, which floats its unused end.
    assign regfile_shift_lsb_port_i = regfile_shift_lsb_port_oe ? regfile_shift_lsb_port_o : f[0];
    assign regfile_shift_msb_port_i = regfile_shift_msb_port_oe ? regfile_shift_msb_port_o
        : f[WIDTH-1];
    assign aux_shift_lsb_port_i = aux_shift_lsb_port_oe ? aux_shift_lsb_port_o : q_q[0];
    assign aux_shift_msb_port_i = aux_shift_msb_port_oe ? aux_shift_msb_port_o : q_q[WIDTH-1];

    // All slices shift together at the edge closing the execute cycle.
    always_ff @(posedge pclk) begin
        if (q_load) begin
            q_q <= q_init;
            shift_cnt <= 8'h00;
        end else if (shift_enable) begin
            shift_cnt <= shift_cnt + 8'h01;
            rf_in_q <= shift_direction_bit[0] ? regfile_shift_lsb_port_i
                : regfile_shift_msb_port_i;
            if (aux_shift_enable) begin
                q_q <= shift_direction_bit[0] ? {q_q[WIDTH-2:0], aux_shift_lsb_port_i}
                    : {aux_shift_msb_port_i, q_q[WIDTH-1:1]};
            end
        end
    end
endmodule : slice_array_model

// >>> bench/tb_slice_ctl.sv
// Purpose: Self-checking bench for the slice-array controller over APB.
// Assumes: Zero-wait APB slave; status settles within eight cycles of issue.
// Notes: Expected values are worked out here from the operands only.
`timescale 1ns/1ps
module tb_slice_ctl;
    import slice_ctl_pkg::*;
    localparam int W = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, q_load = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, shift_enable, aux_shift_enable, slice_carry_in, err_seen;
    logic [3:0] shift_direction_bit;
    logic regfile_shift_lsb_port_i, regfile_shift_lsb_port_o, regfile_shift_lsb_port_oe;
    logic regfile_shift_msb_port_i, regfile_shift_msb_port_o, regfile_shift_msb_port_oe;
    logic aux_shift_lsb_port_i, aux_shift_lsb_port_o, aux_shift_lsb_port_oe;
    logic aux_shift_msb_port_i, aux_shift_msb_port_o, aux_shift_msb_port_oe;
    logic zero_line, slice_carry_out, signed_overflow_flag, result_sign_bit, rf_in_q;
    logic [W-1:0] op_a = 16'h0000, op_b = 16'h0000, q_init = 16'h0000, q_q, eq;
    logic [7:0] shift_cnt;
    logic [W:0] sum;
    logic er, ea;
    int fails = 0, n_checks = 0, cycles = 0;

    always #12.5 pclk = ~pclk;

    slice_ctl #(.WIDTH(W)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .shift_direction_bit, .shift_enable, .aux_shift_enable,
        .slice_carry_in, .regfile_shift_lsb_port_i, .regfile_shift_lsb_port_o,
        .regfile_shift_lsb_port_oe, .regfile_shift_msb_port_i, .regfile_shift_msb_port_o,
        .regfile_shift_msb_port_oe, .aux_shift_lsb_port_i, .aux_shift_lsb_port_o,
        .aux_shift_lsb_port_oe, .aux_shift_msb_port_i, .aux_shift_msb_port_o,
        .aux_shift_msb_port_oe, .zero_line, .slice_carry_out, .signed_overflow_flag,
        .result_sign_bit);
    slice_array_model #(.WIDTH(W)) array_m (.pclk, .shift_direction_bit, .shift_enable,
        .aux_shift_enable, .slice_carry_in, .regfile_shift_lsb_port_o,
        .regfile_shift_lsb_port_oe, .regfile_shift_msb_port_o, .regfile_shift_msb_port_oe,
        .aux_shift_lsb_port_o, .aux_shift_lsb_port_oe, .aux_shift_msb_port_o,
        .aux_shift_msb_port_oe, .regfile_shift_lsb_port_i, .regfile_shift_msb_port_i,
        .aux_shift_lsb_port_i, .aux_shift_msb_port_i, .zero_line, .slice_carry_out,
        .signed_overflow_flag, .result_sign_bit, .op_a, .op_b, .q_load, .q_init, .q_q,
        .rf_in_q, .shift_cnt);

    // Compare one value and count it.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h00_0000, off};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus

    // Load the aux register, issue one microword, then read the status.
    task automatic issue(input logic [5:0] w);
        @(posedge pclk);
        q_load <= 1'b1;
        @(posedge pclk);
        q_load <= 1'b0;
        bus(1'b1, OFF_CTRL, {26'h000_0000, w});
        bus(1'b1, OFF_ISSUE, 32'h0000_0001);
        bus(1'b0, OFF_STATUS, 32'h0000_0000);
        check("busy high", {31'h0, rd[STAT_BUSY_BIT]}, 32'h0000_0001);
        repeat (8) @(posedge pclk);
        bus(1'b0, OFF_STATUS, 32'h0000_0000);
        check("busy", {31'h0, rd[STAT_BUSY_BIT]}, 32'h0000_0000);
    endtask : issue

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        logic [W-1:0] ta[5] = '{16'h0000, 16'hFFFF, 16'h7FFF, 16'h8000, 16'h1234};
        logic [W-1:0] tb[5] = '{16'h0000, 16'h0001, 16'h0000, 16'h8000, 16'h0000};
        logic tc[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b0, OFF_CTRL, 32'h0000_0000);
        check("ctrl reset", rd, CTRL_RESET);
        bus(1'b0, 8'h10, 32'h0000_0000);
        check("unmapped data", rd, 32'h0000_0000);
        check("unmapped error", {31'h0, err_seen}, 32'h0000_0001);
        $display("test reset done");
        // Flags, carry chain and carry in, with no shift.
        for (int k = 0; k < 5; k++) begin
            op_a <= ta[k];
            op_b <= tb[k];
            sum = {1'b0, ta[k]} + {1'b0, tb[k]} + {16'h0000, tc[k]};
            issue({tc[k], 5'h00});
            ea = (ta[k][W-1] == tb[k][W-1]) && (sum[W-1] != ta[k][W-1]);
            check("flags", {28'h0, rd[3:0]}, {28'h0, sum[W-1], ea, sum[W], sum[W-1:0] == 0});
            check("no shift", {24'h0, shift_cnt}, 32'h0000_0000);
            bus(1'b0, OFF_RESULT, 32'h0000_0000);
            check("end lines", rd, {28'h0, sum[0], sum[W-1], 2'b00});
        end
        $display("test flags done");
        // Every mode in both directions, with two operand sets.
        for (int s = 0; s < 2; s++) begin
            for (int d = 0; d < 2; d++) begin
                for (int m = 0; m < 4; m++) begin
                    op_a <= s ? 16'h4002 : 16'hC001;
                    op_b <= 16'h0000;
                    q_init <= s ? 16'hC001 : 16'h4002;
                    eq = s ? 16'hC001 : 16'h4002;
                    sum = s ? 17'h0_4002 : 17'h0_C001;
                    if (d == 1) begin
                        {er, ea} = m == 0 ? 2'b00 : m == 1 ? 2'b11
                            : m == 2 ? {sum[W-1], eq[W-1]} : {eq[W-1], 1'b0};
                        eq = {eq[W-2:0], ea};
                    end else begin
                        {er, ea} = m == 0 ? 2'b00 : m == 1 ? 2'b11
                            : m == 2 ? {sum[0], eq[0]} : {sum[W-1], sum[0]};
                        eq = {ea, eq[W-1:1]};
                    end
                    issue({3'b011, d[0], m[1:0]});
                    check("shift in", {31'h0, rf_in_q}, {31'h0, er});
                    check("aux word", {16'h0000, q_q}, {16'h0000, eq});
                    check("one shift", {24'h0, shift_cnt}, 32'h0000_0001);
                end
            end
        end
        $display("test shift modes done");
        give_verdict();
    end
endmodule : tb_slice_ctl
